// *** inc/rpg_pkg.sv ***
// Constants, register map and reset values of the RF pulse gate block
package rpg_pkg;
    // Clock and timing
    localparam int          CLK_HZ_INT   = 200_000_000;
    localparam logic [27:0] CLK_HZ       = 28'(CLK_HZ_INT);
    localparam logic [27:0] ACC_PER_PCT  = 28'(CLK_HZ_INT / 100);
    localparam int          MIN_PULSE_US = 50;
    localparam logic [7:0]  CYC_PER_US   = 8'(CLK_HZ_INT / 1_000_000);
    localparam logic [31:0] US_PER_PCTHZ = 32'h0000_2710;
    localparam logic [31:0] MIN_PULSE_K  = 32'(MIN_PULSE_US);
    // Frequency and duty limits
    localparam logic [15:0] FREQ_MIN_HZ  = 16'h03E8;
    localparam logic [15:0] FREQ_MAX_HZ  = 16'h4D58;
    localparam logic [6:0]  DUTY_FULL    = 7'h64;
    // Reset values
    localparam logic [15:0] FREQ_RST     = 16'h03E8;
    localparam logic [6:0]  DUTY_RST     = 7'h32;
    // Read-back codes
    localparam logic [31:0] TRIG_FREE    = 32'h0000_0001;
    localparam logic [31:0] RSVD_FILL    = 32'h0000_00FF;
    localparam logic [31:0] RSVD_ZERO    = 32'h0000_0000;
    // Register byte offsets
    localparam logic [7:0]  OFS_FREQ     = 8'h00;
    localparam logic [7:0]  OFS_RSV0     = 8'h04;
    localparam logic [7:0]  OFS_TRIG     = 8'h08;
    localparam logic [7:0]  OFS_RSV1     = 8'h0C;
    localparam logic [7:0]  OFS_RSV2     = 8'h10;
    localparam logic [7:0]  OFS_RSV3     = 8'h14;
    localparam logic [7:0]  OFS_RSV4     = 8'h18;
    localparam logic [7:0]  OFS_DUTY     = 8'h1C;
    localparam logic [7:0]  OFS_TIMED    = 8'h20;
    localparam logic [7:0]  OFS_STATUS   = 8'h24;
    // Timed enable request fields
    localparam int          TIMED_EN_BIT = 31;
endpackage

// *** hdl/rpg_top.sv ***
// RF pulse gate, trigger and timed RF enable with an AHB-Lite register slave
// Operation
// - Frequency accepted from 1000 Hz upward
// - Average power scales with on-fraction
// - Trigger pulse emitted inside each on-pulse that starts on a period wrap
// - Above upper frequency RF stays on
// - Frequency write ignores reserved field, answers OKAY
// - Duty accepted from zero to hundred percent
// - Hundred percent duty leaves RF on
// - Duty giving pulse under 50 us rejected
// - Settings read in documented field order
// - Trigger mode reads one, free running
// - Timed request raises RF once, enable one
// - Timed enable independent of modulation
//
// Local design decisions: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
module rpg_top
    import rpg_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             rfGate,
    output logic             measTrig,
    output logic             rfTimed
);

    // Bus state
    logic        wrPend_r, wrPend_nxt;
    logic [7:0]  wrAddr_r, wrAddr_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    // Configuration state
    logic [15:0] freqCfg_r, freqCfg_nxt;
    logic [6:0]  dutyCfg_r, dutyCfg_nxt;
    logic        dutyRej_r, dutyRej_nxt;
    logic        freqRej_r, freqRej_nxt;
    // Generator state
    logic [27:0] acc_r, acc_nxt;
    logic [15:0] freqAct_r, freqAct_nxt;
    logic [6:0]  dutyAct_r, dutyAct_nxt;
    logic        gate_r, gate_nxt;
    logic        trig_r, trig_nxt;
    // Timed enable state
    logic [7:0]  usCnt_r, usCnt_nxt;
    logic [30:0] remain_r, remain_nxt;
    logic        timed_r, timed_nxt;

    logic        addrPhase;
    logic        wrFreq, wrDuty, wrTimed;
    logic        dutyOk, freqOk, wrap, modOff;
    logic [28:0] accSum;
    logic [31:0] onTimeK, limitK;

    assign addrPhase = hsel & htrans[1] & hready;
    assign wrFreq    = wrPend_r & (wrAddr_r == OFS_FREQ);
    assign wrDuty    = wrPend_r & (wrAddr_r == OFS_DUTY);
    assign wrTimed   = wrPend_r & (wrAddr_r == OFS_TIMED) & hwdata[TIMED_EN_BIT];

    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;
    assign rfGate    = gate_r;
    assign measTrig  = trig_r;
    assign rfTimed   = timed_r;

    // Register read mux in settings order
    function automatic logic [31:0] regRead(input logic [7:0] a);
        logic [31:0] v;
        v = RSVD_ZERO;
        unique case (a)
            OFS_FREQ:   v = {16'h0000, freqCfg_r};
            OFS_TRIG:   v = TRIG_FREE;
            OFS_RSV0:   v = RSVD_ZERO;
            OFS_RSV1,
            OFS_RSV2,
            OFS_RSV3,
            OFS_RSV4:   v = RSVD_FILL;
            OFS_DUTY:   v = {25'h0000000, dutyCfg_r};
            OFS_STATUS: v = {27'h0000000, modOff, freqRej_r, dutyRej_r, timed_r, gate_r};
            default:    v = RSVD_ZERO;
        endcase
        return v;
    endfunction

    // Address phase capture and read data
    always_comb begin
        wrPend_nxt = addrPhase & hwrite;
        wrAddr_nxt = addrPhase ? haddr[7:0] : wrAddr_r;
        hrdata_nxt = (addrPhase & ~hwrite) ? regRead(haddr[7:0]) : hrdata_r;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wrPend_r <= 1'b0;
            wrAddr_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
        end else begin
            wrPend_r <= wrPend_nxt;
            wrAddr_r <= wrAddr_nxt;
            hrdata_r <= hrdata_nxt;
        end
    end

    // On-time check in us times frequency units
    assign onTimeK = 32'(hwdata[6:0]) * US_PER_PCTHZ;
    assign limitK  = MIN_PULSE_K * 32'(freqCfg_r);
    always_comb begin
        dutyOk = 1'b0;
        if (hwdata[31:0] <= 32'(DUTY_FULL)) begin
            dutyOk = (hwdata[6:0] == 7'h00) || (hwdata[6:0] == DUTY_FULL)
                     || (onTimeK >= limitK);
        end
    end
    assign freqOk = hwdata[15:0] >= FREQ_MIN_HZ;

    // Configuration writes, frequency reserved upper half ignored, duty rejected if the whole word exceeds 100
    always_comb begin
        freqCfg_nxt = freqCfg_r;
        freqRej_nxt = freqRej_r;
        dutyCfg_nxt = dutyCfg_r;
        dutyRej_nxt = dutyRej_r;
        if (wrFreq) begin
            freqRej_nxt = ~freqOk;
            if (freqOk) begin
                freqCfg_nxt = hwdata[15:0];
            end
        end
        if (wrDuty) begin
            dutyRej_nxt = ~dutyOk;
            if (dutyOk) begin
                dutyCfg_nxt = hwdata[6:0];
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            freqCfg_r <= FREQ_RST;
            freqRej_r <= 1'b0;
            dutyCfg_r <= DUTY_RST;
            dutyRej_r <= 1'b0;
        end else begin
            freqCfg_r <= freqCfg_nxt;
            freqRej_r <= freqRej_nxt;
            dutyCfg_r <= dutyCfg_nxt;
            dutyRej_r <= dutyRej_nxt;
        end
    end

    // Phase accumulator period generator
    assign accSum = {1'b0, acc_r} + {13'h0000, freqAct_r};
    assign wrap   = accSum >= {1'b0, CLK_HZ};
    assign modOff = (dutyAct_r == DUTY_FULL) || (freqAct_r > FREQ_MAX_HZ);
    always_comb begin
        acc_nxt     = wrap ? 28'(accSum - {1'b0, CLK_HZ}) : accSum[27:0];
        freqAct_nxt = wrap ? freqCfg_r : freqAct_r;
        dutyAct_nxt = wrap ? dutyCfg_r : dutyAct_r;
        if (modOff) begin
            gate_nxt = 1'b1;
        end else begin
            gate_nxt = acc_nxt < (28'(dutyAct_r) * ACC_PER_PCT);
        end
        trig_nxt = wrap & gate_nxt;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            acc_r     <= 28'h0000000;
            freqAct_r <= FREQ_RST;
            dutyAct_r <= DUTY_RST;
            gate_r    <= 1'b0;
            trig_r    <= 1'b0;
        end else begin
            acc_r     <= acc_nxt;
            freqAct_r <= freqAct_nxt;
            dutyAct_r <= dutyAct_nxt;
            gate_r    <= gate_nxt;
            trig_r    <= trig_nxt;
        end
    end

    // One-shot timed enable in microseconds
    always_comb begin
        usCnt_nxt  = usCnt_r;
        remain_nxt = remain_r;
        timed_nxt  = timed_r;
        if (wrTimed) begin
            usCnt_nxt  = 8'h00;
            remain_nxt = hwdata[30:0];
            timed_nxt  = hwdata[30:0] != 31'h00000000;
        end else if (timed_r) begin
            if (usCnt_r == CYC_PER_US - 8'h01) begin
                usCnt_nxt  = 8'h00;
                remain_nxt = remain_r - 31'h00000001;
                timed_nxt  = remain_r != 31'h00000001;
            end else begin
                usCnt_nxt = usCnt_r + 8'h01;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            usCnt_r  <= 8'h00;
            remain_r <= 31'h00000000;
            timed_r  <= 1'b0;
        end else begin
            usCnt_r  <= usCnt_nxt;
            remain_r <= remain_nxt;
            timed_r  <= timed_nxt;
        end
    end

    // Check helpers, cycles since the last timed request
    logic [15:0] timedAge_r, timedAge_nxt;
    logic        twoUsReq_r, twoUsReq_nxt;
    logic [15:0] twoUsLast;

    // Last high cycle of a two microsecond request
    assign twoUsLast = {7'h00, CYC_PER_US, 1'b0} - 16'h0001;

    // Age restarts on every accepted request, saturates when idle
    always_comb begin
        timedAge_nxt = timedAge_r;
        twoUsReq_nxt = twoUsReq_r;
        if (wrTimed) begin
            timedAge_nxt = 16'h0000;
            twoUsReq_nxt = hwdata[30:0] == 31'h00000002;
        end else if (timedAge_r != 16'hFFFF) begin
            timedAge_nxt = timedAge_r + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            timedAge_r <= 16'h0000;
            twoUsReq_r <= 1'b0;
        end else begin
            timedAge_r <= timedAge_nxt;
            twoUsReq_r <= twoUsReq_nxt;
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence timedReq;
        wrPend_r && wrAddr_r == OFS_TIMED && hwdata[TIMED_EN_BIT] && hwdata[30:0] == 31'h00000002;
    endsequence

    sequence timedTwoUs;
        rfTimed [*8] ##0 (usCnt_r == 8'h07);
    endsequence

    // Inside a two microsecond pulse, no new request
    sequence timedTwoUsRun;
        twoUsReq_r && rfTimed && !wrTimed && timedAge_r < twoUsLast;
    endsequence

    // Last cycle of a two microsecond pulse, no new request
    sequence timedTwoUsDone;
        twoUsReq_r && !wrTimed && timedAge_r == twoUsLast;
    endsequence

    chk_short_reject: assert property (wrDuty && !dutyOk |=> dutyCfg_r == $past(dutyCfg_r) && dutyRej_r)
        else $error("short duty accepted");
    chk_duty_take: assert property (wrDuty && dutyOk |=> dutyCfg_r == $past(hwdata[6:0]) && !dutyRej_r)
        else $error("valid duty not stored");
    chk_freq_floor: assert property (freqCfg_r >= FREQ_MIN_HZ)
        else $error("frequency below floor");
    chk_full_on: assert property (dutyAct_r == DUTY_FULL |=> rfGate)
        else $error("full duty not continuous");
    chk_high_freq: assert property (freqAct_r > FREQ_MAX_HZ |=> rfGate)
        else $error("high frequency still gated");
    chk_zero_off: assert property (dutyAct_r == 7'h00 && freqAct_r <= FREQ_MAX_HZ |=> !rfGate)
        else $error("zero duty gives RF");
    chk_trig_inside: assert property (measTrig |-> rfGate)
        else $error("trigger outside on-pulse");
    chk_load_edge: assert property ($changed(dutyAct_r) || $changed(freqAct_r) |-> $past(wrap))
        else $error("setting loaded mid period");
    chk_trig_read: assert property (addrPhase && !hwrite && haddr[7:0] == OFS_TRIG |=> hrdata == TRIG_FREE)
        else $error("trigger mode not free running");
    chk_timed_start: assert property (timedReq |=> timedTwoUs)
        else $error("timed enable did not start");
    chk_timed_hold: assert property (timedTwoUsRun |=> rfTimed)
        else $error("timed enable ended early");
    chk_timed_end: assert property (timedTwoUsDone |=> !rfTimed && remain_r == 31'h00000000)
        else $error("timed enable did not end");
    chk_trig_single: assert property (measTrig |=> !measTrig)
        else $error("trigger longer than one cycle");
    chk_okay_resp: assert property (hreadyout && !hresp)
        else $error("bad AHB response");

endmodule

// *** verif/rpg_host_model.sv ***
// Host-side AHB-Lite master issuing register commands
`timescale 1ns/1ps
module rpg_host_model
    import rpg_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata,
    output logic             timedOut
);
    // Minimum measurable pulse of the attached amplifier
    localparam logic [31:0] AMP_PULSE_US = 32'h0000_003E;
    // Idle bus at time zero
    initial begin
        {hsel, haddr, htrans, hwrite, hwdata, timedOut} = '0;
        hsize = 3'h2;
    end
    // Bounded wait for hready at a rising edge
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) timedOut <= 1'b1;
    endtask
    // One single word transfer, address then data phase
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge ref_clk);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        r = hrdata;
    endtask
    // Frequency command, reserved half kept zero, 1-2 kHz preferred
    task automatic set_freq(input logic [15:0] hz);
        logic [31:0] r;
        xfer(1'b1, OFS_FREQ, {16'h0000, hz}, r);
    endtask
    // Duty command never below frequency times the amplifier pulse
    task automatic set_duty(input logic [15:0] hz, input logic [6:0] pct);
        logic [31:0] r;
        logic [31:0] minDutyPercent;
        minDutyPercent = (32'(hz) * AMP_PULSE_US + US_PER_PCTHZ - 32'h0000_0001) / US_PER_PCTHZ;
        if (32'(pct) < minDutyPercent) pct = 7'(minDutyPercent);
        xfer(1'b1, OFS_DUTY, {25'h0000000, pct}, r);
    endtask
    // Timed enable command, enable bit always one
    task automatic timed_on(input logic [30:0] us);
        logic [31:0] r;
        xfer(1'b1, OFS_TIMED, {1'b1, us}, r);
    endtask
endmodule

// *** verif/rpg_top_tb_top.sv ***
// Self-checking bench for the RF pulse gate block
`timescale 1ns/1ps
module rpg_top_tb_top
    import rpg_pkg::*;
;
    logic        ref_clk, rst, hsel, hwrite, hready, hreadyout, hresp;
    logic        rfGate, measTrig, rfTimed, timedOut, fell;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    int          miscompares, cmp_count, hiCnt, tl, n;
    assign hready = hreadyout;
    rpg_top dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .rfGate(rfGate), .measTrig(measTrig), .rfTimed(rfTimed));
    rpg_host_model host (.ref_clk(ref_clk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .timedOut(timedOut));
    // 200 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] msk, input logic [31:0] exp);
        host.xfer(1'b0, a, 32'h0, rd);
        check(nm, rd & msk, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rd);
    endtask
    // Length of one timed pulse in cycles, bounded
    task automatic timed_len(output int c);
        c = 0;
        n = 0;
        #1;
        while ((c == 0 || rfTimed === 1'b1) && n < 1000) begin
            if (rfTimed === 1'b1) c++;
            @(posedge ref_clk);
            #1;
            n++;
        end
    endtask
    // Hang cut short
    always @(posedge timedOut) begin
        miscompares++;
        end_of_test();
    end
    // First on-pulse length and trigger inside on-time
    always @(negedge ref_clk) begin
        if (!rst && rfGate === 1'b1 && !fell) hiCnt++;
        else if (hiCnt > 0) fell = 1'b1;
        if (measTrig === 1'b1) check("trig in pulse", 32'(rfGate), 32'h1);
    end
    // Main sequence
    initial begin
        rst = 1'b1;
        fell = 1'b0;
        {miscompares, cmp_count, hiCnt} = '0;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        rd_chk("freq", OFS_FREQ, '1, 32'h000003E8);
        rd_chk("rsv0", OFS_RSV0, '1, RSVD_ZERO);
        rd_chk("trig", OFS_TRIG, '1, TRIG_FREE);
        for (int a = 12; a <= 24; a += 4) rd_chk("rsv", 8'(a), '1, RSVD_FILL);
        rd_chk("duty", OFS_DUTY, '1, 32'h00000032);
        rd_chk("unmapped", 8'h40, '1, 32'h0);
        check("hresp", 32'(hresp), 32'h0);
        $display("test map done");
        host.set_freq(16'h03E7);
        rd_chk("freq low", OFS_FREQ, '1, 32'h000003E8);
        rd_chk("freq rej", OFS_STATUS, 32'h8, 32'h8);
        host.set_freq(FREQ_MAX_HZ);
        rd_chk("freq max", OFS_FREQ, '1, 32'h00004D58);
        wr(OFS_DUTY, 32'h62);
        rd_chk("duty 98", OFS_DUTY, '1, 32'h00000032);
        rd_chk("duty rej", OFS_STATUS, 32'hC, 32'h4);
        wr(OFS_DUTY, 32'h63);
        rd_chk("duty 99", OFS_DUTY, '1, 32'h00000063);
        wr(OFS_DUTY, 32'h65);
        rd_chk("duty 101", OFS_DUTY, '1, 32'h00000063);
        wr(OFS_DUTY, 32'h0);
        rd_chk("duty 0", OFS_DUTY, '1, 32'h0);
        wr(OFS_DUTY, 32'h64);
        rd_chk("duty 100", OFS_DUTY, '1, 32'h00000064);
        host.set_freq(16'h07D0);
        rd_chk("freq field", OFS_FREQ, 32'h0000FFFF, 32'h000007D0);
        host.set_duty(16'h07D0, 7'h32);
        rd_chk("duty 50", OFS_DUTY, '1, 32'h00000032);
        rd_chk("gate flag", OFS_STATUS, 32'h1, 32'h1);
        $display("test settings done");
        wr(OFS_TIMED, 32'h00000002);
        timed_len(tl);
        check("timed no enable", 32'(tl), 32'h0);
        host.timed_on(31'h2);
        timed_len(tl);
        check("timed len", 32'(tl), 32'd400);
        host.timed_on(31'h2);
        repeat (100) @(posedge ref_clk);
        host.timed_on(31'h2);
        timed_len(tl);
        check("timed restart", 32'(tl), 32'd400);
        $display("test timed done");
        n = 0;
        while (!fell && n < 120000) begin
            @(posedge ref_clk);
            n++;
        end
        check("gate fell", 32'(fell), 32'h1);
        check("gate on-time", 32'(hiCnt >= 99999 && hiCnt <= 100001), 32'h1);
        $display("test gate done");
        end_of_test();
    end
endmodule
